// *** core/scan_port_cfg.svh ***
// Constants of the scan test port: codes, widths and reset values
`ifndef SCAN_PORT_CFG_SVH
`define SCAN_PORT_CFG_SVH

// Instruction register
`define IR_WIDTH        4
`define IR_CAPTURE      4'h1
`define IR_BYPASS       4'hf
`define IR_EMU_CTRL     4'h2
// Emulator control data register fields
`define EMU_DR_WIDTH    4
`define EMU_A_OE_BIT    0
`define EMU_A_OUT_BIT   1
`define EMU_B_OE_BIT    2
`define EMU_B_OUT_BIT   3
`define EMU_CTL_RESET   4'h0
// Pin synchroniser input positions
`define SYNC_WIDTH      5
`define SYNC_TCK        0
`define SYNC_TMS        1
`define SYNC_TDI        2
`define SYNC_EMU_A      3
`define SYNC_EMU_B      4

`endif

// *** core/scan_port_pkg.sv ***
// Types of the scan test port
package scan_port_pkg;

    // Sixteen controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } tap_state_type;

endpackage

// *** core/scan_test_port.sv ***
// Scan test access port with emulator lines and output-disable control
`timescale 1ns/1ns
`include "scan_port_cfg.svh"

module scan_test_port
    import scan_port_pkg::*;
(
    input  wire logic SYS_CLK,
    input  wire logic RST_B,
    input  wire logic TEST_CLK,
    input  wire logic TEST_MODE_SEL,
    input  wire logic TEST_DATA_IN,
    input  wire logic TEST_RESET,
    output logic      TEST_DATA_OUT,
    output logic      TEST_DATA_OUT_OE,
    input  wire logic EMULATOR_LINE_A_IN,
    output logic      EMULATOR_LINE_A_OUT,
    output logic      EMULATOR_LINE_A_OE,
    input  wire logic EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN,
    output logic      EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OUT,
    output logic      EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE,
    output logic      SCAN_CONTROL,
    output logic      OUTPUTS_DISABLE_B
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    logic [`SYNC_WIDTH-1:0]   sync1_reg;
    logic [`SYNC_WIDTH-1:0]   sync2_reg;
    logic                     trst1_reg;
    logic                     trst2_reg;
    logic                     tck_prev_reg;
    logic                     tck_rise;
    logic                     tck_fall;
    logic                     tms;
    logic                     tdi;
    logic                     off_cond;

    // Two flip-flops on the test clock, mode select, data and both emulator line inputs
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN, EMULATOR_LINE_A_IN,
                          TEST_DATA_IN, TEST_MODE_SEL, TEST_CLK};
            sync2_reg <= sync1_reg;
        end
    end

    // Test reset synchroniser, low at system reset
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            trst1_reg <= 1'b0;
            trst2_reg <= 1'b0;
        end
        else
        begin
            trst1_reg <= TEST_RESET;
            trst2_reg <= trst1_reg;
        end
    end

    // Previous test-clock level
    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            tck_prev_reg <= 1'b0;
        else
            tck_prev_reg <= sync2_reg[`SYNC_TCK];
    end

    assign tck_rise = trst2_reg && sync2_reg[`SYNC_TCK] && !tck_prev_reg;
    assign tck_fall = trst2_reg && !sync2_reg[`SYNC_TCK] && tck_prev_reg;
    assign tms      = sync2_reg[`SYNC_TMS];
    assign tdi      = sync2_reg[`SYNC_TDI];
    assign off_cond = !trst2_reg && sync2_reg[`SYNC_EMU_A] && !sync2_reg[`SYNC_EMU_B];

    ////////////////////////////////////////////////////////////////////////////
    // Controller state machine

    tap_state_type state_reg;
    tap_state_type state_next;

    // Next state from mode select
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            TAP_RESET:    state_next = tms ? TAP_RESET   : TAP_IDLE;
            TAP_IDLE:     state_next = tms ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_DR:   state_next = tms ? TAP_SEL_IR  : TAP_CAP_DR;
            TAP_CAP_DR:   state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: state_next = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: state_next = tms ? TAP_UPD_DR  : TAP_PAUSE_DR;
            TAP_PAUSE_DR: state_next = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: state_next = tms ? TAP_UPD_DR  : TAP_SHIFT_DR;
            TAP_UPD_DR:   state_next = tms ? TAP_SEL_DR  : TAP_IDLE;
            TAP_SEL_IR:   state_next = tms ? TAP_RESET   : TAP_CAP_IR;
            TAP_CAP_IR:   state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: state_next = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: state_next = tms ? TAP_UPD_IR  : TAP_PAUSE_IR;
            TAP_PAUSE_IR: state_next = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: state_next = tms ? TAP_UPD_IR  : TAP_SHIFT_IR;
            TAP_UPD_IR:   state_next = tms ? TAP_SEL_DR  : TAP_IDLE;
            default:      state_next = TAP_RESET;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            state_reg <= TAP_RESET;
        else if (!trst2_reg)
            state_reg <= TAP_RESET;
        else if (tck_rise)
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction and data registers

    logic [`IR_WIDTH-1:0]     ir_shift_reg;
    logic [`IR_WIDTH-1:0]     ir_reg;
    logic                     bypass_reg;
    logic [`EMU_DR_WIDTH-1:0] emu_shift_reg;
    logic [`EMU_DR_WIDTH-1:0] emu_ctl_reg;
    logic                     sel_emu;

    assign sel_emu = (ir_reg == `IR_EMU_CTRL);

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            ir_shift_reg <= `IR_CAPTURE;
            ir_reg       <= `IR_BYPASS;
        end
        else if (state_reg == TAP_RESET)
            ir_reg <= `IR_BYPASS;
        else if (tck_rise)
        begin
            case (state_reg)
                TAP_CAP_IR:   ir_shift_reg <= `IR_CAPTURE;
                TAP_SHIFT_IR: ir_shift_reg <= {tdi, ir_shift_reg[`IR_WIDTH-1:1]};
                TAP_UPD_IR:   ir_reg <= ir_shift_reg;
                default:      ir_reg <= ir_reg;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            bypass_reg    <= 1'b0;
            emu_shift_reg <= `EMU_CTL_RESET;
        end
        else if (tck_rise)
        begin
            case (state_reg)
                TAP_CAP_DR:
                begin
                    bypass_reg    <= 1'b0;
                    emu_shift_reg <= emu_ctl_reg;
                    emu_shift_reg[`EMU_A_OUT_BIT] <= sync2_reg[`SYNC_EMU_A];
                    emu_shift_reg[`EMU_B_OUT_BIT] <= sync2_reg[`SYNC_EMU_B];
                end
                TAP_SHIFT_DR:
                begin
                    if (sel_emu)
                        emu_shift_reg <= {tdi, emu_shift_reg[`EMU_DR_WIDTH-1:1]};
                    else
                        bypass_reg <= tdi;
                end
                default: bypass_reg <= bypass_reg;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            emu_ctl_reg <= `EMU_CTL_RESET;
        else if (state_reg == TAP_RESET)
            emu_ctl_reg <= `EMU_CTL_RESET;
        else if (tck_rise && state_reg == TAP_UPD_DR && sel_emu)
            emu_ctl_reg <= emu_shift_reg;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic tdo_active_reg;

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            TEST_DATA_OUT  <= 1'b0;
            tdo_active_reg <= 1'b0;
        end
        else if (!trst2_reg)
            tdo_active_reg <= 1'b0;
        else if (tck_fall)
        begin
            tdo_active_reg <= (state_reg == TAP_SHIFT_IR) || (state_reg == TAP_SHIFT_DR);
            if (state_reg == TAP_SHIFT_IR)
                TEST_DATA_OUT <= ir_shift_reg[0];
            else if (state_reg == TAP_SHIFT_DR)
                TEST_DATA_OUT <= sel_emu ? emu_shift_reg[0] : bypass_reg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
            TEST_DATA_OUT_OE <= 1'b0;
        else
            TEST_DATA_OUT_OE <= tdo_active_reg && !off_cond && trst2_reg;
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            EMULATOR_LINE_A_OUT                   <= 1'b0;
            EMULATOR_LINE_A_OE                    <= 1'b0;
            EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OUT <= 1'b0;
            EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE  <= 1'b0;
        end
        else
        begin
            EMULATOR_LINE_A_OUT <= emu_ctl_reg[`EMU_A_OUT_BIT];
            EMULATOR_LINE_A_OE  <= trst2_reg && emu_ctl_reg[`EMU_A_OE_BIT];
            EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OUT <= emu_ctl_reg[`EMU_B_OUT_BIT];
            EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE  <= trst2_reg && emu_ctl_reg[`EMU_B_OE_BIT];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            OUTPUTS_DISABLE_B <= 1'b1;
            SCAN_CONTROL      <= 1'b0;
        end
        else
        begin
            OUTPUTS_DISABLE_B <= !off_cond;
            SCAN_CONTROL      <= trst2_reg;
        end
    end

endmodule // scan_test_port

// *** testbench/scan_test_port_assertions.sv ***
// Checker of the scan test port pin behaviour
`timescale 1ns/1ns
module scan_test_port_checker
(
    input wire logic SYS_CLK,
    input wire logic RST_B,
    input wire logic TEST_CLK,
    input wire logic TEST_RESET,
    input wire logic TEST_DATA_OUT,
    input wire logic TEST_DATA_OUT_OE,
    input wire logic EMULATOR_LINE_A_IN,
    input wire logic EMULATOR_LINE_A_OE,
    input wire logic EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN,
    input wire logic EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE,
    input wire logic SCAN_CONTROL,
    input wire logic OUTPUTS_DISABLE_B
);
    // Pin condition that asks for all outputs off, and any line driven
    wire off_cond = !TEST_RESET && EMULATOR_LINE_A_IN && !EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN;
    wire lines_oe = EMULATOR_LINE_A_OE || EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    ////////////////////////////////////////////////////////////////////////////
    tdo_off_float_a: assert property (
        !OUTPUTS_DISABLE_B |-> ##[0:2] !TEST_DATA_OUT_OE)
        else $error("data output driven while disabled");
    lines_off_float_a: assert property (
        !OUTPUTS_DISABLE_B |-> ##[0:2] !lines_oe)
        else $error("emulator line driven while disabled");
    off_active_a: assert property (
        off_cond [*5] |-> !OUTPUTS_DISABLE_B)
        else $error("disable condition not honoured");
    off_idle_a: assert property (
        !off_cond [*5] |-> OUTPUTS_DISABLE_B)
        else $error("outputs disabled without condition");
    scan_on_a: assert property (
        TEST_RESET [*5] |-> SCAN_CONTROL)
        else $error("scan control not taken");
    func_quiet_a: assert property (
        !TEST_RESET [*5] |-> !SCAN_CONTROL && !lines_oe && !TEST_DATA_OUT_OE)
        else $error("scan side active in functional mode");
    // Pin fall lies two synchroniser stages and one register back from the change
    tdo_fall_edge_a: assert property (
        SCAN_CONTROL && $changed(TEST_DATA_OUT) |-> !$past(TEST_CLK, 3) && $past(TEST_CLK, 4))
        else $error("data output changed off falling edge");
    // Enable follows the data output by one more register stage
    oe_rise_edge_a: assert property (
        $rose(TEST_DATA_OUT_OE) |-> !$past(TEST_CLK, 4) && $past(TEST_CLK, 5) && SCAN_CONTROL)
        else $error("data output enabled off falling edge");

    // Main scenarios reached
    cover property (!OUTPUTS_DISABLE_B);
    cover property ($rose(TEST_DATA_OUT_OE));
    cover property ($rose(EMULATOR_LINE_A_OE));
endmodule // scan_test_port_checker

bind scan_test_port scan_test_port_checker chk_u
(
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .TEST_CLK(TEST_CLK), .TEST_RESET(TEST_RESET),
    .TEST_DATA_OUT(TEST_DATA_OUT), .TEST_DATA_OUT_OE(TEST_DATA_OUT_OE),
    .EMULATOR_LINE_A_IN(EMULATOR_LINE_A_IN), .EMULATOR_LINE_A_OE(EMULATOR_LINE_A_OE),
    .EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN(EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN),
    .EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE(EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE),
    .SCAN_CONTROL(SCAN_CONTROL), .OUTPUTS_DISABLE_B(OUTPUTS_DISABLE_B)
);

// *** testbench/scan_ctrl_model.sv ***
// External scan controller model driving the test pins
`timescale 1ns/1ns
module scan_ctrl_model
(
    input  wire logic clk,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    // Test clock rests low between frames
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 320 ns test clock period, entered at a falling system edge
    // select and data held four cycles around rise
    task automatic step(input logic m, input logic d, output logic q, output logic e);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clk);
        e = tdo_oe;
        q = tdo_oe ? tdo : ~tdo; // Released line reads inverted
        tck = 1'b1;
        repeat (4) @(negedge clk);
        tck = 1'b0;
    endtask
endmodule // scan_ctrl_model

// *** testbench/testbench.sv ***
// Self-checking bench of the scan test port
`timescale 1ns/1ns
module testbench;
    logic       clk        = 1'b0;
    logic       rst_b      = 1'b0;
    logic       test_reset = 1'b0;
    logic       drv_a      = 1'b1;
    logic       drv_b      = 1'b1;
    logic [3:0] ctrl       = 4'h0; // Model of emulator control
    logic       tck, tms, tdi, tdo, tdo_oe, a_out, a_oe, b_out, b_oe, scan_ctl, off_b;
    int         fail_count = 0;
    int         checked    = 0;
    int         seed       = 32'hd294;
    // Pin levels: released lines take the bench drive
    wire        line_a     = a_oe ? a_out : drv_a;
    wire        line_b     = b_oe ? b_out : drv_b;

    always #20 clk = ~clk;

    scan_test_port dut_u
    (
        .SYS_CLK(clk), .RST_B(rst_b), .TEST_CLK(tck), .TEST_MODE_SEL(tms),
        .TEST_DATA_IN(tdi), .TEST_RESET(test_reset), .TEST_DATA_OUT(tdo),
        .TEST_DATA_OUT_OE(tdo_oe), .EMULATOR_LINE_A_IN(line_a), .EMULATOR_LINE_A_OUT(a_out),
        .EMULATOR_LINE_A_OE(a_oe), .EMULATOR_LINE_B_OR_OUTPUT_DISABLE_IN(line_b),
        .EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OUT(b_out),
        .EMULATOR_LINE_B_OR_OUTPUT_DISABLE_OE(b_oe), .SCAN_CONTROL(scan_ctl),
        .OUTPUTS_DISABLE_B(off_b)
    );

    scan_ctrl_model ctl
    (
        .clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Compare helpers
    task automatic cmp_word(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({7'h00, got}, {7'h00, exp});
    endtask

    // Full scan from idle back to idle, instruction or data path
    task automatic scan(input logic ir, input int n, input logic [7:0] din,
                        output logic [7:0] dout);
        logic q, e;
        dout = 8'h00;
        ctl.step(1'b1, 1'b0, q, e);
        if (ir)
            ctl.step(1'b1, 1'b0, q, e);
        ctl.step(1'b0, 1'b0, q, e);
        ctl.step(1'b0, 1'b0, q, e);
        for (int i = 0; i < n; i++)
        begin
            ctl.step(i == n - 1, din[i], q, e);
            dout[i] = q;
            cmp_bit(e, 1'b1);
        end
        ctl.step(1'b1, 1'b0, q, e);
        cmp_bit(e, 1'b0);
        ctl.step(1'b0, 1'b0, q, e);
    endtask

    task automatic results();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] got, din;
        logic [3:0] code;
        logic       q, e;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        cmp_word({6'h00, off_b, scan_ctl}, 8'h02);
        test_reset = 1'b1;
        repeat (6) @(negedge clk);
        cmp_bit(scan_ctl, 1'b1);
        for (int i = 0; i < 6; i++)
            ctl.step(i == 5 ? 1'b0 : 1'b1, 1'b0, q, e);
        for (int k = 0; k < 6; k++)
        begin
            code = (k % 3 == 0) ? 4'h2 : (k == 1) ? 4'hf : 4'($random(seed));
            scan(1'b1, 4, {4'h0, code}, got);
            cmp_word(got, 8'h01);
            din = 8'($random(seed));
            if (code == 4'h2)
            begin
                drv_a = din[4];
                drv_b = din[5];
                scan(1'b0, 4, din, got);
                cmp_word(got, {4'h0, ctrl[2] ? ctrl[3] : drv_b, ctrl[2],
                               ctrl[0] ? ctrl[1] : drv_a, ctrl[0]});
                ctrl = din[3:0];
                repeat (4) @(negedge clk);
                cmp_word({4'h0, b_out, b_oe, a_out, a_oe}, {4'h0, ctrl});
            end
            else
            begin
                scan(1'b0, 8, din, got);
                cmp_word(got, {din[6:0], 1'b0});
            end
        end
        // Drop test reset in mid-shift
        for (int i = 0; i < 4; i++)
            ctl.step(i == 0, 1'b0, q, e);
        test_reset = 1'b0;
        ctrl = 4'h0;
        repeat (6) @(negedge clk);
        cmp_word({4'h0, tdo_oe, a_oe, b_oe, scan_ctl}, 8'h00);
        // Every pin combination of the output-disable condition
        for (int i = 0; i < 8; i++)
        begin
            {test_reset, drv_a, drv_b} = 3'(i);
            repeat (6) @(negedge clk);
            cmp_bit(off_b, i != 2);
            cmp_word({5'h00, tdo_oe, a_oe, b_oe}, 8'h00);
        end
        results();
    end

    // Watchdog against a hung run
    initial
    begin
        #400000;
        fail_count++;
        results();
    end
endmodule // testbench
